// ---- csc_pkg.sv ----
// constants, types and bus carriers of the charger smbus command block
package csc_pkg;

  // -----------------------------------------------------------------
  // smbus addresses and command codes
  // -----------------------------------------------------------------
  localparam logic [6:0] SMB_DEV_ADDR  = 7'h09;
  localparam logic [6:0] SMB_ARA_ADDR  = 7'h0c;
  localparam logic [7:0] ARA_REPLY     = 8'h12;
  localparam logic [7:0] CMD_STATUS    = 8'h13;
  localparam logic [7:0] CMD_CURRENT   = 8'h14;
  localparam logic [7:0] CMD_VOLTAGE   = 8'h15;
  localparam logic [7:0] CMD_ALARM     = 8'h16;
  localparam logic [7:0] CMD_VENDOR    = 8'h3c;

  // -----------------------------------------------------------------
  // field layouts and limits
  // -----------------------------------------------------------------
  localparam logic [15:0] ALARM_ACT_MASK = 16'hf000;
  localparam int          PMD_POS        = 12;
  localparam logic [15:0] VOLT_ZERO_MAX  = 16'h044f;
  localparam logic [15:0] I_MAX_GND      = 16'h03ff;
  localparam logic [15:0] I_MAX_10K      = 16'h07ff;
  localparam logic [15:0] I_MAX_33K      = 16'h0bff;
  localparam logic [15:0] I_MAX_OPEN     = 16'h0fff;
  localparam logic [15:0] V_MAX_GND      = 16'h1090;
  localparam logic [15:0] V_MAX_10K      = 16'h10d0;
  localparam logic [15:0] V_MAX_33K      = 16'h1150;
  localparam logic [15:0] V_MAX_100K     = 16'h11a0;
  localparam logic [15:0] V_MAX_OPEN     = 16'h1580;
  localparam logic [15:0] I_FULL_SCALE   = 16'h1000;
  localparam logic [15:0] PULSE_LIM      = I_FULL_SCALE >> 4;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic        PMD_RST        = 1'b0;
  localparam logic        ALERT_RST      = 1'b1;
  localparam logic [15:0] REQ_RST        = 16'h0000;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       sense;
    logic       supply;
    logic       permit;
    logic [1:0] ilim;
    logic [2:0] vlim;
  } csc_pins_s;

  typedef struct packed {
    logic ur;
    logic hot;
    logic cold;
    logic ovr;
  } csc_safety_s;

  typedef struct packed {
    logic adapter_on;
    logic battery_attached;
    logic power_fail;
    logic alarm_block;
    logic underrange;
    logic hot;
    logic cold;
    logic overrange;
    logic voltage_or;
    logic current_or;
    logic rsvd;
    logic level3;
    logic current_notreg;
    logic voltage_notreg;
    logic polling;
    logic charge_inhibited;
  } csc_status_s;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RX    = 5'b00010,
    ST_ACK   = 5'b00100,
    ST_TX    = 5'b01000,
    ST_TXACK = 5'b10000
  } csc_bus_state_e;

endpackage

// ---- csc_charger_regs.sv ----
// smbus slave, command registers and status flags of the battery charger
`timescale 1ns/1ps
module csc_charger_regs
  import csc_pkg::*;
#(
  parameter logic [15:0] VERSION_ID  = 16'h0a05, // arbitrary value
  parameter int          I_STEP_BITS = 2,
  parameter int          V_STEP_BITS = 4
) (
  input  wire logic        mclk,                   // 10 mhz clock
  input  wire logic        srst,                   // sync reset, high
  input  wire logic        ce,                     // clock enable
  input  wire logic        scl_in,                 // smbus clock pin
  input  wire logic        sda_in,                 // smbus data pin
  output logic             sda_out,                // data drive level
  output logic             sda_oe,                 // data pull-down on
  input  wire logic        adapter_sense_input,    // sense comparator
  input  wire logic        adapter_supply_input,   // supply high enough
  input  wire logic        charge_permit_input,    // permit pin level
  input  wire logic [1:0]  current_limit_strap,    // current strap code
  input  wire logic [2:0]  voltage_limit_strap,    // voltage strap code
  input  wire logic        safety_sample_valid,    // decoder sample pulse
  input  wire csc_safety_s safety_range,           // decoded range
  output logic             alert_pulldown_output,  // alert pull-down on
  output csc_status_s      charger_status_flags,   // status word
  output logic [15:0]      current_setting,        // applied current
  output logic [15:0]      voltage_setting,        // applied voltage
  output logic             charge_enable,          // charging allowed
  output logic             low_current_pulse_mode  // pulsed mode on
);

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  csc_pins_s pin_raw;
  csc_pins_s pin_meta;
  csc_pins_s pin_s;
  logic      scl_d;
  logic      sda_d;

  assign pin_raw = '{scl: scl_in, sda: sda_in,
                     sense: adapter_sense_input,
                     supply: adapter_supply_input,
                     permit: charge_permit_input,
                     ilim: current_limit_strap,
                     vlim: voltage_limit_strap};

  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_meta <= '1;
      pin_s    <= '1;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else if (ce) begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
      scl_d    <= pin_s.scl;
      sda_d    <= pin_s.sda;
    end
  end

  wire start_det = pin_s.scl & scl_d & sda_d & ~pin_s.sda;
  wire stop_det  = pin_s.scl & scl_d & ~sda_d & pin_s.sda;
  wire scl_rise  = pin_s.scl & ~scl_d;
  wire scl_fall  = ~pin_s.scl & scl_d;

  // -----------------------------------------------------------------
  // flags and request storage
  // -----------------------------------------------------------------
  logic        adapter_on;
  logic        battery_attached;
  logic        alarm_block;
  logic        pulse_mode_disable;
  logic        alert_active;
  logic [15:0] req_current;
  logic [15:0] req_voltage;
  logic        seen_current;
  logic        seen_voltage;
  logic [1:0]  clean_cnt;
  csc_safety_s range_q;
  logic [15:0] i_max;
  logic [15:0] v_max;

  // -----------------------------------------------------------------
  // smbus engine state
  // -----------------------------------------------------------------
  csc_bus_state_e state;
  logic [7:0]     shreg;
  logic [3:0]     bitcnt;
  logic [2:0]     byte_idx;
  logic           rd_mode;
  logic           ara_mode;
  logic           tx_hi;
  logic           mack;
  logic [7:0]     cmd_reg;
  logic [7:0]     lo_reg;
  logic [15:0]    rd_word_q;
  logic           wr_stb;
  logic [15:0]    wr_word;
  logic           ara_done;

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  wire dev_hit = (shreg[7:1] == SMB_DEV_ADDR);
  wire ara_hit = (shreg[7:1] == SMB_ARA_ADDR) & shreg[0]
                 & alert_active;
  wire addr_hit = dev_hit | ara_hit;

  wire wr_current = wr_stb & (cmd_reg == CMD_CURRENT);
  wire wr_voltage = wr_stb & (cmd_reg == CMD_VOLTAGE);
  wire wr_alarm   = wr_stb & (cmd_reg == CMD_ALARM);
  wire wr_vendor  = wr_stb & (cmd_reg == CMD_VENDOR);

  // only the four top alarm bits block charging; the rest are dropped
  wire alarm_hit = wr_alarm & |(wr_word & ALARM_ACT_MASK);

  wire power_fail = ~pin_s.supply | ~pin_s.permit;

  wire sample_ovr = safety_sample_valid & safety_range.ovr;
  wire sample_ok  = safety_sample_valid & ~safety_range.ovr;
  // a second clean sample in a row attaches the battery
  wire attach_evt = sample_ok & ~battery_attached
                    & (clean_cnt == 2'd1);
  wire detach_evt = sample_ovr & battery_attached;

  wire next_battery = attach_evt ? 1'b1 :
                      (sample_ovr ? 1'b0 : battery_attached);

  wire alarm_clear = (seen_current & seen_voltage)
                     | ~pin_s.sense | ~next_battery;

  wire [15:0] vendor_word = VERSION_ID
                 | (16'(pulse_mode_disable) << PMD_POS);

  csc_status_s status_now;
  assign status_now = '{adapter_on: adapter_on,
                        battery_attached: battery_attached,
                        power_fail: power_fail,
                        alarm_block: alarm_block,
                        underrange: range_q.ur,
                        hot: range_q.hot,
                        cold: range_q.cold,
                        overrange: range_q.ovr,
                        voltage_or: req_voltage > v_max,
                        current_or: req_current > i_max,
                        rsvd: 1'b0,
                        level3: 1'b1,
                        current_notreg: 1'b0,
                        voltage_notreg: 1'b0,
                        polling: 1'b0,
                        charge_inhibited: 1'b0};

  wire [15:0] rd_word = (cmd_reg == CMD_STATUS) ? status_now :
                        (cmd_reg == CMD_VENDOR) ? vendor_word : 16'h0000;
  wire [7:0]  first_tx = ara_mode ? ARA_REPLY : rd_word_q[7:0];

  // -----------------------------------------------------------------
  // strap limits and clamping
  // -----------------------------------------------------------------
  assign i_max = (pin_s.ilim == 2'd0) ? I_MAX_GND :
                 (pin_s.ilim == 2'd1) ? I_MAX_10K :
                 (pin_s.ilim == 2'd2) ? I_MAX_33K : I_MAX_OPEN;

  assign v_max = (pin_s.vlim == 3'd0) ? V_MAX_GND  :
                 (pin_s.vlim == 3'd1) ? V_MAX_10K  :
                 (pin_s.vlim == 3'd2) ? V_MAX_33K  :
                 (pin_s.vlim == 3'd3) ? V_MAX_100K : V_MAX_OPEN;

  wire [15:0] i_clamp = (req_current > i_max) ? i_max : req_current;
  wire [15:0] i_apply = i_clamp & ~16'((1 << I_STEP_BITS) - 1);

  wire        v_small = (req_voltage <= VOLT_ZERO_MAX);
  wire [15:0] v_clamp = (req_voltage > v_max) ? v_max : req_voltage;
  wire [15:0] v_apply = v_small ? 16'h0000
                        : (v_clamp & ~16'((1 << V_STEP_BITS) - 1));

  // charging needs an attached battery and no blocking condition
  wire chg_ok = battery_attached & ~alarm_block & ~power_fail
                & adapter_on & (i_apply != 16'h0000)
                & (v_apply != 16'h0000);

  // -----------------------------------------------------------------
  // smbus slave engine
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      state     <= ST_IDLE;
      shreg     <= 8'h00;
      bitcnt    <= 4'h0;
      byte_idx  <= 3'h0;
      rd_mode   <= 1'b0;
      ara_mode  <= 1'b0;
      tx_hi     <= 1'b0;
      mack      <= 1'b0;
      cmd_reg   <= 8'h00;
      lo_reg    <= 8'h00;
      rd_word_q <= 16'h0000;
      wr_stb    <= 1'b0;
      wr_word   <= 16'h0000;
      ara_done  <= 1'b0;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
    end else if (ce) begin
      wr_stb   <= 1'b0;
      ara_done <= 1'b0;
      if (start_det) begin
        state    <= ST_RX;
        bitcnt   <= 4'h0;
        byte_idx <= 3'h0;
        sda_oe   <= 1'b0;
      end else if (stop_det) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], pin_s.sda};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              bitcnt   <= 4'h0;
              byte_idx <= byte_idx + 3'h1;
              if (byte_idx == 3'h0) begin
                if (addr_hit) begin
                  rd_mode   <= shreg[0];
                  ara_mode  <= ara_hit;
                  tx_hi     <= 1'b0;
                  rd_word_q <= rd_word;
                  sda_oe    <= 1'b1;
                  state     <= ST_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (byte_idx <= 3'h3) begin
                if (byte_idx == 3'h1) begin
                  cmd_reg <= shreg;
                end
                if (byte_idx == 3'h2) begin
                  lo_reg <= shreg;
                end
                if (byte_idx == 3'h3) begin
                  wr_stb  <= 1'b1;
                  wr_word <= {shreg, lo_reg};
                end
                sda_oe <= 1'b1;
                state  <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (rd_mode) begin
                shreg  <= first_tx;
                sda_oe <= ~first_tx[7];
                state  <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state  <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              // a released one seen low means another sender won
              if (shreg[7] && !pin_s.sda) begin
                sda_oe <= 1'b0;
                state  <= ST_IDLE;
              end else begin
                bitcnt <= bitcnt + 4'h1;
              end
            end else if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe <= 1'b0;
                state  <= ST_TXACK;
              end else begin
                shreg  <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              mack     <= ~pin_s.sda;
              ara_done <= ara_mode;
            end else if (scl_fall) begin
              if (mack && !ara_mode && !tx_hi) begin
                tx_hi  <= 1'b1;
                bitcnt <= 4'h0;
                shreg  <= rd_word_q[15:8];
                sda_oe <= ~rd_word_q[15];
                state  <= ST_TX;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // safety signal flags
  // -----------------------------------------------------------------
  // the decoder reports underrange only below its low trip point, so
  // the flag is its sample taken as is; sample pacing when unpowered
  // is the decoder's and may lag attach as allowed
  always_ff @(posedge mclk) begin
    if (srst) begin
      range_q          <= '0;
      battery_attached <= 1'b0;
      clean_cnt        <= 2'd0;
    end else if (ce) begin
      if (safety_sample_valid) begin
        range_q <= safety_range;
      end
      battery_attached <= next_battery;
      if (sample_ovr) begin
        clean_cnt <= 2'd0;
      end else if (sample_ok && clean_cnt != 2'd2) begin
        clean_cnt <= clean_cnt + 2'd1;
      end
    end
  end

  // -----------------------------------------------------------------
  // requests, alarm block and vendor mode
  // -----------------------------------------------------------------
  // supply faults only gate charging; the stored requests survive
  always_ff @(posedge mclk) begin
    if (srst) begin
      req_current        <= REQ_RST;
      req_voltage        <= REQ_RST;
      seen_current       <= 1'b0;
      seen_voltage       <= 1'b0;
      alarm_block        <= 1'b0;
      pulse_mode_disable <= PMD_RST;
      adapter_on         <= 1'b0;
    end else if (ce) begin
      adapter_on <= pin_s.sense;
      if (detach_evt) begin
        req_current <= REQ_RST;
        req_voltage <= REQ_RST;
      end else begin
        if (wr_current) begin
          req_current <= wr_word;
        end
        if (wr_voltage) begin
          req_voltage <= wr_word;
        end
      end
      if (alarm_hit) begin
        alarm_block  <= 1'b1;
        seen_current <= 1'b0;
        seen_voltage <= 1'b0;
      end else begin
        seen_current <= seen_current | wr_current;
        seen_voltage <= seen_voltage | wr_voltage;
        if (alarm_clear) begin
          alarm_block <= 1'b0;
        end
      end
      if (wr_vendor) begin
        pulse_mode_disable <= wr_word[PMD_POS];
      end
    end
  end

  // -----------------------------------------------------------------
  // alert line and outputs
  // -----------------------------------------------------------------
  wire alert_evt = (pin_s.sense != adapter_on)
                   | (next_battery != battery_attached)
                   | (alarm_hit & ~alarm_block);

  always_ff @(posedge mclk) begin
    if (srst) begin
      alert_active           <= ALERT_RST;
      alert_pulldown_output  <= ALERT_RST;
      charger_status_flags   <= '0;
      current_setting        <= REQ_RST;
      voltage_setting        <= REQ_RST;
      charge_enable          <= 1'b0;
      low_current_pulse_mode <= 1'b0;
    end else if (ce) begin
      // a new event in the release cycle keeps the line pulled
      if (alert_evt) begin
        alert_active          <= 1'b1;
        alert_pulldown_output <= 1'b1;
      end else if (ara_done) begin
        alert_active          <= 1'b0;
        alert_pulldown_output <= 1'b0;
      end
      charger_status_flags <= status_now;
      current_setting      <= chg_ok ? i_apply : REQ_RST;
      voltage_setting      <= chg_ok ? v_apply : REQ_RST;
      charge_enable        <= chg_ok;
      low_current_pulse_mode <= chg_ok & ~pulse_mode_disable
                                & (i_apply < PULSE_LIM);
    end
  end

endmodule // csc_charger_regs

// ---- csc_smb_master.sv ----
// smbus master model standing on the far side of the charger block
`timescale 1ns/1ps
module csc_smb_master
  import csc_pkg::*;
(
  input  wire logic        mclk,     // bench clock
  output logic             scl,      // bus clock level
  output logic             sda_drv,  // 0 pulls data low
  input  wire logic        sda,      // resolved data wire
  output logic             ack_ok,   // every written byte acked
  output logic             rd_valid, // read result pulse
  output logic [15:0]      rd_word   // read result
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    ack_ok = 1'b0;
    rd_valid = 1'b0;
    rd_word = 16'h0000;
  end
  // phases of 5 mclk keep us above the 4-cycle sync minimum
  task automatic ph();
    repeat (5) @(negedge mclk);
  endtask
  // data moves only mid-low so no false start or stop is seen
  task automatic bitx(input logic b, output logic r);
    ph();
    sda_drv = b;
    ph();
    scl = 1'b1;
    ph();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    sda_drv = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_drv = 1'b0;
    ph();
    scl = 1'b0;
  endtask
  task automatic stop();
    ph();
    sda_drv = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_drv = 1'b1;
    ph();
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack_ok = ack_ok & ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
  task automatic post(input logic [15:0] w);
    rd_word = w;
    rd_valid = 1'b1;
    @(negedge mclk);
    rd_valid = 1'b0;
  endtask
  // word write, low byte first, 16-bit value
  task automatic wr(input logic [7:0] cmd, input logic [15:0] v);
    ack_ok = 1'b1;
    start();
    wbyte({SMB_DEV_ADDR, 1'b0});
    wbyte(cmd);
    wbyte(v[7:0]);
    wbyte(v[15:8]);
    stop();
  endtask
  task automatic rd(input logic [7:0] cmd);
    logic [15:0] w;
    ack_ok = 1'b1;
    start();
    wbyte({SMB_DEV_ADDR, 1'b0});
    wbyte(cmd);
    start();
    wbyte({SMB_DEV_ADDR, 1'b1});
    rbyte(1'b0, w[7:0]);
    rbyte(1'b1, w[15:8]);
    stop();
    post(w);
  endtask
  task automatic ara();
    logic [7:0] b;
    ack_ok = 1'b1;
    start();
    wbyte({SMB_ARA_ADDR, 1'b1});
    rbyte(1'b1, b);
    stop();
    post({8'h00, b});
  endtask
endmodule // csc_smb_master

// ---- csc_charger_regs_sva.sv ----
// port assertions for the charger command block
`timescale 1ns/1ps
module csc_charger_regs_sva
  import csc_pkg::*;
#(
  parameter int I_STEP_BITS = 2,
  parameter int V_STEP_BITS = 4
) (
  input wire logic        mclk,                  // clock
  input wire logic        srst,                  // reset
  input wire logic [1:0]  current_limit_strap,   // current strap
  input wire logic [2:0]  voltage_limit_strap,   // voltage strap
  input wire logic        safety_sample_valid,   // sample pulse
  input wire csc_safety_s safety_range,          // sample range
  input wire logic        alert_pulldown_output, // alert on
  input wire csc_status_s charger_status_flags,  // status
  input wire logic [15:0] current_setting,       // applied current
  input wire logic [15:0] voltage_setting,       // applied voltage
  input wire logic        charge_enable          // charging on
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire [15:0] imax = current_limit_strap == 2'd0 ? I_MAX_GND :
                     current_limit_strap == 2'd1 ? I_MAX_10K :
                     current_limit_strap == 2'd2 ? I_MAX_33K : I_MAX_OPEN;
  wire [15:0] vmax = voltage_limit_strap == 3'd0 ? V_MAX_GND :
                     voltage_limit_strap == 3'd1 ? V_MAX_10K :
                     voltage_limit_strap == 3'd2 ? V_MAX_33K :
                     voltage_limit_strap == 3'd3 ? V_MAX_100K : V_MAX_OPEN;
  wire [15:0] imsk = (16'h0001 << I_STEP_BITS) - 16'h0001;
  wire [15:0] vmsk = (16'h0001 << V_STEP_BITS) - 16'h0001;
  alert_attach_a: assert property (
    $changed(charger_status_flags.battery_attached)
    |-> ##[0:2] alert_pulldown_output) else $error("no alert on attach");
  alert_adapter_a: assert property (
    $changed(charger_status_flags.adapter_on)
    |-> ##[0:2] alert_pulldown_output) else $error("no alert on adapter");
  alert_alarm_a: assert property (
    $rose(charger_status_flags.alarm_block)
    |-> ##[0:2] alert_pulldown_output) else $error("no alert on alarm");
  ovr_detach_a: assert property (
    safety_sample_valid && safety_range.ovr
    |-> ##[1:3] !charger_status_flags.battery_attached)
    else $error("overrange kept battery");
  detach_clear_a: assert property (
    !charger_status_flags.battery_attached [*3]
    |-> current_setting == 16'h0000 && voltage_setting == 16'h0000
        && !charge_enable) else $error("charging while detached");
  fail_block_a: assert property (
    charger_status_flags.power_fail [*3] |-> !charge_enable)
    else $error("charging in supply fault");
  cur_limit_a: assert property (
    current_setting <= imax && (current_setting & imsk) == 16'h0000)
    else $error("current setting out of limit");
  volt_limit_a: assert property (
    voltage_setting <= vmax && (voltage_setting & vmsk) == 16'h0000
    && (voltage_setting == 16'h0000 || voltage_setting > VOLT_ZERO_MAX))
    else $error("voltage setting out of limit");
endmodule // csc_charger_regs_sva

// ---- tb.sv ----
// self-checking bench for the charger command block
`timescale 1ns/1ps
module tb;
  import csc_pkg::*;
  localparam logic [15:0] VER = 16'h0a05; // arbitrary version code
  logic        mclk, srst, sense, supply, permit, sv, sda_oe, sda_out, alert;
  logic        scl, sda_drv, ack_ok, rd_valid, cen, pulse;
  logic [15:0] rd_word, cur, volt, st, c, e, im;
  logic [1:0]  il;
  logic [2:0]  vl;
  csc_safety_s rng;
  csc_status_s sts;
  int          failures, compares, cyc = 0;
  logic [15:0] expq[$];
  wire         sda = sda_drv & ~(sda_oe & ~sda_out);
  csc_charger_regs #(.VERSION_ID(VER)) uut (.mclk(mclk), .srst(srst),
    .ce(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .adapter_sense_input(sense),
    .adapter_supply_input(supply), .charge_permit_input(permit),
    .current_limit_strap(il), .voltage_limit_strap(vl),
    .safety_sample_valid(sv), .safety_range(rng),
    .alert_pulldown_output(alert), .charger_status_flags(sts),
    .current_setting(cur), .voltage_setting(volt), .charge_enable(cen),
    .low_current_pulse_mode(pulse));
  csc_smb_master m (.mclk(mclk), .scl(scl), .sda_drv(sda_drv),
    .sda(sda), .ack_ok(ack_ok), .rd_valid(rd_valid), .rd_word(rd_word));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] xs();
    st = st ^ (st << 7);
    st = st ^ (st >> 9);
    st = st ^ (st << 8);
    return st;
  endfunction
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic samp(input logic ovr);
    @(negedge mclk);
    sv = 1'b1;
    rng = '{ur: ~ovr, hot: ~ovr, cold: ovr, ovr: ovr};
    @(negedge mclk);
    sv = 1'b0;
  endtask
  task automatic ara_ok();
    expq.push_back({8'h00, ARA_REPLY});
    m.ara();
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // results are compared as the bus model reports them
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rd_valid === 1'b1)
      check(rd_word, expq.size() ? expq.pop_front() : 16'hxxxx);
    if (cyc == 60000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    {srst, sense, supply, permit, sv, rng, il, vl} = {5'b11110, 4'h0, 5'b01010};
    {failures, compares, st} = {32'd0, 32'd0, 16'd80};
    w(2);
    srst = 1'b0;
    w(6);
    check(16'(alert), 16'h1);
    ara_ok();
    w(4);
    check(16'(alert), 16'h0);
    expq.push_back(16'h00ff);
    m.ara();
    check(16'(ack_ok), 16'h0);
    samp(1'b0);
    w(3);
    check(16'(sts.battery_attached), 16'h0);
    samp(1'b0);
    w(4);
    check(16'(sts.battery_attached), 16'h1);
    check(16'(alert), 16'h1);
    ara_ok();
    expq.push_back(16'hcc10);
    m.rd(CMD_STATUS);
    expq.push_back(VER);
    m.rd(CMD_VENDOR);
    for (int k = 0; k < 3; k++) begin
      il = 2'(k + 1);
      im = k == 0 ? I_MAX_10K : k == 1 ? I_MAX_33K : I_MAX_OPEN;
      c = k == 0 ? xs() & 16'h0fff : k == 1 ? 16'h0903 : 16'h0043;
      m.wr(CMD_CURRENT, c);
      m.wr(CMD_VOLTAGE, 16'h1000);
      e = c > im ? im : c;
      e[1:0] = 2'b00;
      check(cur, e);
      check(16'(sts.current_or), 16'(c > im));
      check(16'(pulse), 16'(e != 16'h0 && e < PULSE_LIM));
    end
    m.wr(CMD_VENDOR, 16'hffff);
    check(16'(pulse), 16'h0);
    expq.push_back(VER | 16'h1000);
    m.rd(CMD_VENDOR);
    for (int k = 0; k < 3; k++) begin
      vl = 3'(k + 2);
      im = k == 0 ? V_MAX_33K : k == 1 ? V_MAX_100K : V_MAX_OPEN;
      c = k == 0 ? VOLT_ZERO_MAX : k == 1 ? 16'h0450 : xs();
      m.wr(CMD_VOLTAGE, c);
      e = c <= VOLT_ZERO_MAX ? 16'h0 : c > im ? im : c;
      e[3:0] = 4'h0;
      check(volt, e);
      check(16'(sts.voltage_or), 16'(c > im));
      check(16'(cen), 16'(e != 16'h0));
    end
    m.wr(CMD_VOLTAGE, 16'h1000);
    for (int k = 0; k < 2; k++) begin
      {supply, permit} = k ? 2'b01 : 2'b10;
      w(8);
      check(16'({sts.power_fail, cen}), 16'h2);
      {supply, permit} = 2'b11;
      w(8);
      check(cur, 16'h0040);
    end
    m.wr(CMD_ALARM, 16'h0fff);
    check(16'(sts.alarm_block), 16'h0);
    for (int k = 0; k < 4; k++) begin
      m.wr(CMD_ALARM, 16'h1000 << k);
      check(16'({sts.alarm_block, cen, alert}), 16'h5);
      ara_ok();
      m.wr(CMD_CURRENT, 16'h0040);
      check(16'(sts.alarm_block), 16'h1);
      m.wr(CMD_VOLTAGE, 16'h1000);
      check(16'({sts.alarm_block, cen}), 16'h1);
    end
    samp(1'b1);
    w(4);
    check(16'({sts.battery_attached, alert}), 16'h1);
    samp(1'b0);
    samp(1'b0);
    w(4);
    check(cur | volt, 16'h0);
    sense = 1'b0;
    w(6);
    check(16'(sts.adapter_on), 16'h0);
    end_of_test();
  end
endmodule // tb
bind csc_charger_regs csc_charger_regs_sva #(.I_STEP_BITS(I_STEP_BITS),
  .V_STEP_BITS(V_STEP_BITS)) chk (.mclk(mclk), .srst(srst),
  .current_limit_strap(current_limit_strap),
  .voltage_limit_strap(voltage_limit_strap),
  .safety_sample_valid(safety_sample_valid), .safety_range(safety_range),
  .alert_pulldown_output(alert_pulldown_output),
  .charger_status_flags(charger_status_flags),
  .current_setting(current_setting), .voltage_setting(voltage_setting),
  .charge_enable(charge_enable));
